/* bdes_top.sv */
// Module: APB event selection and two general counters for branch and dispatch events
// Functional notes
// - Code 8eh mask 00h counts executed mispredicted indirect branches.
// - Codes 8fh, 90h, 91h count all, mispredicted, decode-missed returns.
// - Codes 92h, 93h, 94h count all, mispredicted and indirect calls.
// - Codes 97h and 98h each count taken-prediction one-cycle penalties.
// - Code a0h mask 00h adds micro-ops dispatched per cycle, up to six.
// - Code a1h masks 01h, 02h, 04h count cycles ports 0, 1, 2 dispatched, on counter 0 only.
module bdes_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ind_br_mispredict,
  input wire logic ret_exec,
  input wire logic ret_mispredict,
  input wire logic ret_decode_mispredict,
  input wire logic call_exec,
  input wire logic call_mispredict,
  input wire logic ind_call_exec,
  input wire logic taken_penalty_a,
  input wire logic taken_penalty_b,
  input wire logic [2:0] dispatch_uops,
  input wire logic [2:0] port_dispatch,
  output logic [2:0] incr0,
  output logic [2:0] incr1
);
  import bdes_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [BDES_SEL_W-1:0] sel0;
    logic [BDES_SEL_W-1:0] sel1;
    logic [BDES_CNT_W-1:0] cnt0;
    logic [BDES_CNT_W-1:0] cnt1;
    logic [2:0] incr0;
    logic [2:0] incr1;
    logic [31:0] rdata;
    logic err;
  } bdes_state_t;

  bdes_state_t st;
  bdes_state_t next_st;
  logic [2:0] dec0;
  logic [2:0] dec1;
  logic setup;
  logic wr_acc;
  logic hit_sel0;
  logic hit_sel1;
  logic hit_cnt0;
  logic hit_cnt1;

  function automatic logic sel_on(input logic [BDES_SEL_W-1:0] s);
    sel_on = s[BDES_EN_BIT];
  endfunction

  // ****************************************
  // Event decoders
  // ****************************************
  bdes_decode u_dec0 (
    .event_code(st.sel0[BDES_CODE_LSB +: 8]),
    .unit_mask(st.sel0[BDES_MASK_LSB +: 8]),
    .port_ok(1'b1),
    .ind_br_mispredict(ind_br_mispredict),
    .ret_exec(ret_exec),
    .ret_mispredict(ret_mispredict),
    .ret_decode_mispredict(ret_decode_mispredict),
    .call_exec(call_exec),
    .call_mispredict(call_mispredict),
    .ind_call_exec(ind_call_exec),
    .taken_penalty_a(taken_penalty_a),
    .taken_penalty_b(taken_penalty_b),
    .dispatch_uops(dispatch_uops),
    .port_dispatch(port_dispatch),
    .incr(dec0)
  );

  // Per-port dispatch is not counted on counter 1
  bdes_decode u_dec1 (
    .event_code(st.sel1[BDES_CODE_LSB +: 8]),
    .unit_mask(st.sel1[BDES_MASK_LSB +: 8]),
    .port_ok(1'b0),
    .ind_br_mispredict(ind_br_mispredict),
    .ret_exec(ret_exec),
    .ret_mispredict(ret_mispredict),
    .ret_decode_mispredict(ret_decode_mispredict),
    .call_exec(call_exec),
    .call_mispredict(call_mispredict),
    .ind_call_exec(ind_call_exec),
    .taken_penalty_a(taken_penalty_a),
    .taken_penalty_b(taken_penalty_b),
    .dispatch_uops(dispatch_uops),
    .port_dispatch(port_dispatch),
    .incr(dec1)
  );

  // ****************************************
  // APB decode
  // ****************************************
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign hit_sel0 = (paddr == BDES_SEL0_OFF);
  assign hit_sel1 = (paddr == BDES_SEL1_OFF);
  assign hit_cnt0 = (paddr == BDES_CNT0_OFF);
  assign hit_cnt1 = (paddr == BDES_CNT1_OFF);

  always_comb begin
    next_st = st;
    next_st.incr0 = sel_on(st.sel0) ? dec0 : 3'h0;
    next_st.incr1 = sel_on(st.sel1) ? dec1 : 3'h0;
    next_st.cnt0 = st.cnt0 + {29'h0, next_st.incr0};
    next_st.cnt1 = st.cnt1 + {29'h0, next_st.incr1};
    if (setup) begin
      next_st.err = !(hit_sel0 || hit_sel1 || hit_cnt0 || hit_cnt1);
      next_st.rdata = 32'h00000000;
      if (!pwrite) begin
        if (hit_sel0) begin
          next_st.rdata = {15'h0, st.sel0};
        end else if (hit_sel1) begin
          next_st.rdata = {15'h0, st.sel1};
        end else if (hit_cnt0) begin
          next_st.rdata = st.cnt0;
        end else if (hit_cnt1) begin
          next_st.rdata = st.cnt1;
        end
      end
    end
    // Software writes win over the same-cycle increment
    if (wr_acc) begin
      if (hit_sel0) begin
        next_st.sel0 = pwdata[BDES_SEL_W-1:0];
      end
      if (hit_sel1) begin
        next_st.sel1 = pwdata[BDES_SEL_W-1:0];
      end
      if (hit_cnt0) begin
        next_st.cnt0 = pwdata;
      end
      if (hit_cnt1) begin
        next_st.cnt1 = pwdata;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st.sel0 <= BDES_SEL_RST;
      st.sel1 <= BDES_SEL_RST;
      st.cnt0 <= BDES_CNT_RST;
      st.cnt1 <= BDES_CNT_RST;
      st.incr0 <= 3'h0;
      st.incr1 <= 3'h0;
      st.rdata <= 32'h00000000;
      st.err <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && st.err;
  assign incr0 = st.incr0;
  assign incr1 = st.incr1;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic [7:0] code0;
  logic [7:0] mask0;
  logic on0;
  assign code0 = st.sel0[BDES_CODE_LSB +: 8];
  assign mask0 = st.sel0[BDES_MASK_LSB +: 8];
  assign on0 = sel_on(st.sel0);

  ind_mispredict_a: assert property (
    on0 && code0 == BDES_EV_IND_MISP && mask0 == BDES_UM_NONE
    |=> incr0 == {2'h0, $past(ind_br_mispredict)})
    else $error("indirect mispredict increment wrong");

  return_count_a: assert property (
    on0 && mask0 == BDES_UM_NONE && code0 == BDES_EV_RET_DEC_MISP
    |=> incr0 == {2'h0, $past(ret_decode_mispredict)})
    else $error("return decode mispredict increment wrong");

  call_count_a: assert property (
    on0 && mask0 == BDES_UM_NONE && code0 == BDES_EV_CALL_MISP
    ##0 call_mispredict |=> incr0 == 3'h1)
    else $error("call mispredict not counted");

  bubble_count_a: assert property (
    on0 && mask0 == BDES_UM_NONE && code0 == BDES_EV_BUBBLE_B
    && !taken_penalty_b |=> incr0 == 3'h0)
    else $error("penalty b counted without event");

  dispatch_total_a: assert property (
    on0 && mask0 == BDES_UM_NONE && code0 == BDES_EV_DISP
    && dispatch_uops <= BDES_DISP_MAX |=> incr0 == $past(dispatch_uops))
    else $error("dispatch total increment wrong");

  port_cycles_a: assert property (
    on0 && code0 == BDES_EV_PORT_DISP && mask0 == BDES_UM_PORT1
    |=> incr0 == {2'h0, $past(port_dispatch[1])})
    else $error("port 1 dispatch increment wrong");

  port_ctr1_zero_a: assert property (
    st.sel1[BDES_CODE_LSB +: 8] == BDES_EV_PORT_DISP |=> incr1 == 3'h0)
    else $error("counter 1 counted per-port dispatch");

  undefined_zero_a: assert property (
    code0 == 8'h95 || mask0 == 8'h80 |=> incr0 == 3'h0)
    else $error("undefined selection counted");

  count_accum_a: assert property (
    !(psel && penable) ##1 !(psel && penable)
    |-> st.cnt0 == $past(st.cnt0) + {29'h0, incr0})
    else $error("counter 0 did not accumulate");

  incr_bound_a: assert property (incr0 <= BDES_DISP_MAX)
    else $error("increment above six");

  cover_ret_c: cover property (
    on0 && code0 == BDES_EV_RET ##1 incr0 == 3'h1);
  cover_disp_c: cover property (
    on0 && code0 == BDES_EV_DISP ##1 incr0 == BDES_DISP_MAX);
  cover_port_c: cover property (
    on0 && code0 == BDES_EV_PORT_DISP ##1 incr0 == 3'h1);
  cover_err_c: cover property (pslverr);

endmodule

/* bdes_pkg.sv */
// Package: constants for the branch and dispatch event selection block
package bdes_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] BDES_SEL0_OFF = 12'h000;
  localparam logic [11:0] BDES_SEL1_OFF = 12'h004;
  localparam logic [11:0] BDES_CNT0_OFF = 12'h008;
  localparam logic [11:0] BDES_CNT1_OFF = 12'h00c;

  // ****************************************
  // Select register fields
  // ****************************************
  localparam int BDES_CODE_LSB = 0;
  localparam int BDES_MASK_LSB = 8;
  localparam int BDES_EN_BIT = 16;
  localparam int BDES_SEL_W = 17;
  localparam logic [16:0] BDES_SEL_RST = 17'h00000;
  localparam logic [31:0] BDES_CNT_RST = 32'h00000000;
  localparam int BDES_CNT_W = 32;
  localparam int BDES_INC_W = 3;

  // ****************************************
  // Event codes and unit masks
  // ****************************************
  localparam logic [7:0] BDES_EV_IND_MISP = 8'h8e;
  localparam logic [7:0] BDES_EV_RET = 8'h8f;
  localparam logic [7:0] BDES_EV_RET_MISP = 8'h90;
  localparam logic [7:0] BDES_EV_RET_DEC_MISP = 8'h91;
  localparam logic [7:0] BDES_EV_CALL = 8'h92;
  localparam logic [7:0] BDES_EV_CALL_MISP = 8'h93;
  localparam logic [7:0] BDES_EV_IND_CALL = 8'h94;
  localparam logic [7:0] BDES_EV_BUBBLE_A = 8'h97;
  localparam logic [7:0] BDES_EV_BUBBLE_B = 8'h98;
  localparam logic [7:0] BDES_EV_DISP = 8'ha0;
  localparam logic [7:0] BDES_EV_PORT_DISP = 8'ha1;
  localparam logic [7:0] BDES_UM_NONE = 8'h00;
  localparam logic [7:0] BDES_UM_PORT0 = 8'h01;
  localparam logic [7:0] BDES_UM_PORT1 = 8'h02;
  localparam logic [7:0] BDES_UM_PORT2 = 8'h04;
  localparam logic [2:0] BDES_DISP_MAX = 3'h6;

endpackage

/* bdes_decode.sv */
// Module: maps one event selection to a per-cycle increment
module bdes_decode (
  input wire logic [7:0] event_code,
  input wire logic [7:0] unit_mask,
  input wire logic port_ok,
  input wire logic ind_br_mispredict,
  input wire logic ret_exec,
  input wire logic ret_mispredict,
  input wire logic ret_decode_mispredict,
  input wire logic call_exec,
  input wire logic call_mispredict,
  input wire logic ind_call_exec,
  input wire logic taken_penalty_a,
  input wire logic taken_penalty_b,
  input wire logic [2:0] dispatch_uops,
  input wire logic [2:0] port_dispatch,
  output logic [2:0] incr
);
  import bdes_pkg::*;

  logic [2:0] disp_sat;

  always_comb begin
    disp_sat = (dispatch_uops > BDES_DISP_MAX) ? BDES_DISP_MAX : dispatch_uops;
    incr = 3'h0;
    if (unit_mask == BDES_UM_NONE) begin
      case (event_code)
        BDES_EV_IND_MISP: incr = {2'h0, ind_br_mispredict};
        BDES_EV_RET: incr = {2'h0, ret_exec};
        BDES_EV_RET_MISP: incr = {2'h0, ret_mispredict};
        BDES_EV_RET_DEC_MISP: incr = {2'h0, ret_decode_mispredict};
        BDES_EV_CALL: incr = {2'h0, call_exec};
        BDES_EV_CALL_MISP: incr = {2'h0, call_mispredict};
        BDES_EV_IND_CALL: incr = {2'h0, ind_call_exec};
        BDES_EV_BUBBLE_A: incr = {2'h0, taken_penalty_a};
        BDES_EV_BUBBLE_B: incr = {2'h0, taken_penalty_b};
        BDES_EV_DISP: incr = disp_sat;
        default: incr = 3'h0;
      endcase
    end else if (event_code == BDES_EV_PORT_DISP && port_ok) begin
      case (unit_mask)
        BDES_UM_PORT0: incr = {2'h0, port_dispatch[0]};
        BDES_UM_PORT1: incr = {2'h0, port_dispatch[1]};
        BDES_UM_PORT2: incr = {2'h0, port_dispatch[2]};
        default: incr = 3'h0;
      endcase
    end
  end

endmodule

/* bdes_top_tb.sv */
// Self-checking testbench for the branch and dispatch event selection block
module bdes_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import bdes_pkg::*;
  typedef struct {logic [2:0] e0; logic [2:0] e1;} bdes_note_t;

  // ****************************************
  // Signals and design
  // ****************************************
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr;
  logic [8:0] ev = 9'h000;
  logic [2:0] disp_uops = 3'h0, port_disp = 3'h0, incr0, incr1;
  logic [16:0] sel_m [2] = '{17'h0, 17'h0};
  bdes_note_t notes [$];
  bdes_note_t cur;
  integer seed = 32'h8a9e;
  int n_fail = 0, num_checks = 0;
  // Expected counter values; a counter write drops that edge's increment
  logic [31:0] acc0 = 32'h0, acc1 = 32'h0;
  bit skip0 = 1'b0, skip1 = 1'b0;

  always #10 pclk = ~pclk;

  bdes_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ind_br_mispredict(ev[0]), .ret_exec(ev[1]), .ret_mispredict(ev[2]),
    .ret_decode_mispredict(ev[3]), .call_exec(ev[4]),
    .call_mispredict(ev[5]), .ind_call_exec(ev[6]),
    .taken_penalty_a(ev[7]), .taken_penalty_b(ev[8]),
    .dispatch_uops(disp_uops), .port_dispatch(port_disp),
    .incr0(incr0), .incr1(incr1));

  // ****************************************
  // Expected increment for one selection
  // ****************************************
  function automatic logic [2:0] exp_inc(input logic [16:0] s,
    input logic [8:0] e, input logic [2:0] du, input logic [2:0] pd,
    input bit c0);
    logic b;
    logic [7:0] um;
    um = s[15:8];
    if (s[BDES_EN_BIT] !== 1'b1) return 3'h0;
    case (s[7:0])
      BDES_EV_IND_MISP: b = e[0];
      BDES_EV_RET: b = e[1];
      BDES_EV_RET_MISP: b = e[2];
      BDES_EV_RET_DEC_MISP: b = e[3];
      BDES_EV_CALL: b = e[4];
      BDES_EV_CALL_MISP: b = e[5];
      BDES_EV_IND_CALL: b = e[6];
      BDES_EV_BUBBLE_A: b = e[7];
      BDES_EV_BUBBLE_B: b = e[8];
      BDES_EV_DISP: begin
        if (um != BDES_UM_NONE) return 3'h0;
        return (du > BDES_DISP_MAX) ? BDES_DISP_MAX : du;
      end
      BDES_EV_PORT_DISP: begin
        if (!c0) return 3'h0;
        case (um)
          BDES_UM_PORT0: return {2'h0, pd[0]};
          BDES_UM_PORT1: return {2'h0, pd[1]};
          BDES_UM_PORT2: return {2'h0, pd[2]};
          default: return 3'h0;
        endcase
      end
      default: return 3'h0;
    endcase
    return (um == BDES_UM_NONE) ? {2'h0, b} : 3'h0;
  endfunction

  // ****************************************
  // Drivers
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Random core events for the coming edge, with their expected result
  task automatic step();
    logic [31:0] r;
    bdes_note_t n;
    r = $random(seed);
    ev <= r[8:0];
    disp_uops <= r[14:12];
    port_disp <= r[18:16];
    n.e0 = exp_inc(sel_m[0], r[8:0], r[14:12], r[18:16], 1'b1);
    n.e1 = exp_inc(sel_m[1], r[8:0], r[14:12], r[18:16], 1'b0);
    notes.push_back(n);
  endtask

  task automatic idle(input int n);
    repeat (n) begin
      @(posedge pclk);
      step();
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    step();
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    step();
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      step();
      n++;
      @(posedge pclk);
    end
    if (n >= 50) n_fail++;
    rd = prdata;
    err = pslverr;
    // Selection is live for events sampled after the write edge
    if (wr && a == BDES_SEL0_OFF) sel_m[0] = d[16:0];
    if (wr && a == BDES_SEL1_OFF) sel_m[1] = d[16:0];
    if (wr && a == BDES_CNT0_OFF) begin
      acc0 = d;
      skip0 = 1'b1;
    end
    if (wr && a == BDES_CNT1_OFF) begin
      acc1 = d;
      skip1 = 1'b1;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    step();
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic e;
    apb(1'b1, a, d, rd, e);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] x,
    input logic xe);
    logic [31:0] rd;
    logic e;
    apb(1'b0, a, 32'h0, rd, e);
    chk("prdata", rd, x);
    chk("pslverr", {31'h0, e}, {31'h0, xe});
  endtask

  // ****************************************
  // Output watcher
  // ****************************************
  always @(negedge pclk) begin
    if (notes.size() > 1) begin
      cur = notes.pop_front();
      chk("incr0", {29'h0, incr0}, {29'h0, cur.e0});
      chk("incr1", {29'h0, incr1}, {29'h0, cur.e1});
      if (skip0) skip0 = 1'b0;
      else acc0 = acc0 + {29'h0, cur.e0};
      if (skip1) skip1 = 1'b0;
      else acc1 = acc1 + {29'h0, cur.e1};
    end
  end

  task automatic conclude();
    if (n_fail == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    conclude();
  end

  // ****************************************
  // Scenarios
  // ****************************************
  logic [16:0] cfg [20] = '{17'h1008e, 17'h1008f, 17'h10090, 17'h10091,
    17'h10092, 17'h10093, 17'h10094, 17'h10097, 17'h10098, 17'h100a0,
    17'h101a1, 17'h102a1, 17'h104a1, 17'h1018e, 17'h103a1, 17'h10095,
    17'h100a1, 17'h0008f, 17'h101a0, 17'h1ffff};

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(BDES_SEL0_OFF, 32'h0, 1'b0);
    rd_chk(BDES_SEL1_OFF, 32'h0, 1'b0);
    rd_chk(BDES_CNT0_OFF, 32'h0, 1'b0);
    rd_chk(BDES_CNT1_OFF, 32'h0, 1'b0);
    wr(BDES_CNT1_OFF, 32'h5a5a0f0f);
    rd_chk(BDES_CNT1_OFF, 32'h5a5a0f0f, 1'b0);
    wr(12'h010, 32'hffffffff);
    rd_chk(12'h010, 32'h0, 1'b1);
    wr(BDES_SEL0_OFF, 32'hffffffff);
    rd_chk(BDES_SEL0_OFF, 32'h0001ffff, 1'b0);
    idle(8);
    foreach (cfg[i]) begin
      wr(BDES_SEL0_OFF, {15'h0, cfg[i]});
      wr(BDES_SEL1_OFF, {15'h0, cfg[i]});
      wr(BDES_CNT0_OFF, 32'hffffffc0);
      wr(BDES_CNT1_OFF, 32'h00000000);
      idle(24);
      wr(BDES_SEL0_OFF, 32'h0);
      wr(BDES_SEL1_OFF, 32'h0);
      rd_chk(BDES_CNT0_OFF, acc0, 1'b0);
      rd_chk(BDES_CNT1_OFF, acc1, 1'b0);
    end
    // Reset in mid-run clears selections and counters
    wr(BDES_SEL0_OFF, 32'h0000018e);
    wr(BDES_CNT0_OFF, 32'h12345678);
    presetn <= 1'b0;
    acc0 = 32'h0;
    acc1 = 32'h0;
    idle(3);
    presetn <= 1'b1;
    sel_m[0] = 17'h0;
    rd_chk(BDES_SEL0_OFF, 32'h0, 1'b0);
    rd_chk(BDES_CNT0_OFF, acc0, 1'b0);
    rd_chk(BDES_CNT1_OFF, acc1, 1'b0);
    conclude();
  end
endmodule
